// ==== core/clock_reset_gear_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the clock and reset block
`ifndef CLOCK_RESET_GEAR_REGS_SVH
`define CLOCK_RESET_GEAR_REGS_SVH

// Register byte offsets
`define CRG_CTRL_OFS        12'h000
`define CRG_STATUS_OFS      12'h004
`define CRG_VECTOR_OFS      12'h008

// Control register fields
`define CRG_GEAR_LSB        0
`define CRG_GEAR_MSB        1
`define CRG_SRC_BIT         2
`define CRG_DIVSEL_BIT      3
`define CRG_SUBEN_BIT       4
`define CRG_SLEEP_BIT       5
`define CRG_CTRL_RESET      6'h03

// Status register fields
`define CRG_ST_PLL_BIT      0
`define CRG_ST_GEAR_LSB     1
`define CRG_ST_GEAR_MSB     2
`define CRG_ST_SRC_BIT      3
`define CRG_ST_RST_BIT      4
`define CRG_ST_PER_LSB      16
`define CRG_ST_PER_MSB      31

// Gear codes
`define CRG_GEAR_DIV2       2'h1
`define CRG_GEAR_DIV4       2'h2
`define CRG_GEAR_DIV8       2'h3
`define CRG_GEAR_LAST2      3'h1
`define CRG_GEAR_LAST4      3'h3
`define CRG_GEAR_LAST8      3'h7

// Reset qualification and vector
`define CRG_RESET_LOW_TICKS 4'hC
`define CRG_RESET_VECTOR    32'hBFC0_0000
`define CRG_STRAP_SETTLE    2'h2

// PLL multiplication factor, as accumulator step
`define CRG_PLL_MULT        4

`endif

// ==== core/clock_reset_gear_pkg.sv ====
// Types shared by the clock and reset block
package clock_reset_gear_pkg;

  typedef enum logic {
    SRC_GEARED,
    SRC_SUB
  } sys_src_t;

  typedef logic [1:0] gear_code_t;

endpackage

// ==== core/osc_tick_gen.sv ====
// Pin synchroniser and rising-edge tick for an oscillator input
`timescale 1ns/10ps
`default_nettype none

module osc_tick_gen (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Oscillator pin level
  input  wire logic osc_in,
  // One-cycle pulse per oscillator rising edge
  output logic      tick
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
    logic tick;
  } tick_state_t;

  tick_state_t s_q;
  tick_state_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.meta = osc_in;
    s_d.sync = s_q.meta;
    s_d.last = s_q.sync;
    // Only the second and third stages feed the edge detect
    s_d.tick = s_q.sync & ~s_q.last;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule

`default_nettype wire

// ==== core/clock_reset_gear_control.sv ====
// Clock selection, clock gear, low-power gating and reset control with an APB register port
// Operation
// - reset sets clock gear to divide-by-eight
// - strap sampled at reset picks PLL or bypass
// - PLL gives four times oscillator frequency
// - gear divides main clock by 2,4,8
// - source bit picks geared or sub clock
// - reset initialises core control coprocessor registers
// - core starts at fixed shared reset vector
// - reset returns peripheral registers to defaults
// - reset makes all port pins general-purpose
// - single-clock or dual-clock operation supported
// - sub-clock comes from 32.768 kHz source
// - SLOW mode runs processor from sub-clock
// - SLEEP stops only CPU and peripheral clocks; system, RTC, counter, pull-up clocks run on
`include "clock_reset_gear_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module clock_reset_gear_control
  import clock_reset_gear_pkg::*;
#(
  parameter int PER_W = 16
) (
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Pins
  input  wire logic        main_osc_pins,
  input  wire logic        sub_osc_pins,
  input  wire logic        pll_bypass_strap,
  input  wire logic        ext_reset_n,
  // System clock enables
  output logic             sys_clk,
  output logic             sys_clk_en,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             rtc_clk_en,
  output logic             pulse_cnt_clk_en,
  output logic             pullup_clk_en,
  // Reset effects
  output logic             core_rst_n,
  output logic             cp0_init,
  output logic [31:0]      reset_vector,
  output logic             periph_rst_n,
  output logic             port_default
);

  typedef struct packed {
    // Synchronised pins
    logic             strap_meta;
    logic             strap_sync;
    logic             rst_meta;
    logic             rst_sync;
    // Strap capture
    logic             strap_done;
    logic             pll_on;
    logic [1:0]       strap_age;
    // Oscillator measurement and PLL model
    logic [PER_W-1:0] per_cnt;
    logic [PER_W-1:0] period;
    logic [PER_W+1:0] acc;
    logic             half_tgl;
    // Gear and source
    logic [2:0]       gear_cnt;
    gear_code_t       gear_act;
    sys_src_t         src_act;
    logic             sw_skip;
    // Reset qualification
    logic [3:0]       low_cnt;
    logic             in_reset;
    // Software controls
    gear_code_t       gear_reg;
    logic             src_reg;
    logic             divsel_reg;
    logic             suben_reg;
    logic             sleep_reg;
    // Outputs
    logic             sys_clk;
    logic             sys_en;
    logic             cpu_en;
    logic             periph_en;
    logic             sub_en_out;
    logic             core_rst_n;
    logic             cp0_init;
    logic             periph_rst_n;
    logic             port_default;
    // APB answer
    logic             pready;
    logic [31:0]      prdata;
    logic             pslverr;
  } crg_state_t;

  crg_state_t s_q;
  crg_state_t s_d;

  logic main_tick;
  logic sub_tick;

  osc_tick_gen u_main_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .osc_in  (main_osc_pins),
    .tick    (main_tick)
  );

  osc_tick_gen u_sub_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .osc_in  (sub_osc_pins),
    .tick    (sub_tick)
  );

  function automatic logic [2:0] gear_last(input gear_code_t g);
    logic [2:0] r;
    case (g)
      `CRG_GEAR_DIV4: r = `CRG_GEAR_LAST4;
      `CRG_GEAR_DIV8: r = `CRG_GEAR_LAST8;
      default:        r = `CRG_GEAR_LAST2;
    endcase
    return r;
  endfunction

  logic             osc_tick;
  logic             pll_tick;
  logic             main_clk_tick;
  logic             geared_tick;
  logic             sub_ok;
  logic             sys_tick;
  logic             src_tick;
  sys_src_t         next_src;
  logic             bus_access;
  logic             bus_write;
  logic [PER_W+1:0] acc_next;
  logic [31:0]      rd_word;
  logic             unmapped;

  always_comb begin
    s_d = s_q;

    s_d.strap_meta = pll_bypass_strap;
    s_d.strap_sync = s_q.strap_meta;
    s_d.rst_meta   = ext_reset_n;
    s_d.rst_sync   = s_q.rst_meta;

    // Strap taken on the first settled cycle and again in every qualified reset
    // Pin level only trusted once it has crossed both stages
    if (s_q.strap_age != `CRG_STRAP_SETTLE) begin
      s_d.strap_age = s_q.strap_age + 1'b1;
    end
    if ((!s_q.strap_done && s_q.strap_age == `CRG_STRAP_SETTLE) || s_q.in_reset) begin
      s_d.strap_done = 1'b1;
      s_d.pll_on     = ~s_q.strap_sync;
    end

    // Optional halving of the raw oscillator input
    osc_tick = main_tick;
    if (main_tick && s_q.divsel_reg) begin
      s_d.half_tgl = ~s_q.half_tgl;
      osc_tick     = s_q.half_tgl;
    end

    // Period measured in bus clocks drives the multiplier model
    s_d.per_cnt = s_q.per_cnt + 1'b1;
    if (osc_tick) begin
      s_d.per_cnt = '0;
      s_d.period  = s_q.per_cnt + 1'b1;
    end else if (&s_q.per_cnt) begin
      s_d.per_cnt = s_q.per_cnt;
    end

    // Four evenly spaced ticks per oscillator period; capped at one per bus clock
    acc_next = s_q.acc + (PER_W+2)'(`CRG_PLL_MULT);
    pll_tick = 1'b0;
    if (osc_tick) begin
      s_d.acc  = '0;
      pll_tick = 1'b1;
    end else if (s_q.period != '0 && acc_next >= {2'b00, s_q.period}) begin
      s_d.acc  = acc_next - {2'b00, s_q.period};
      pll_tick = 1'b1;
    end else begin
      s_d.acc  = acc_next;
    end

    main_clk_tick = s_q.pll_on ? pll_tick : osc_tick;

    // Clock gear; new ratio only taken at the end of a whole divided period
    geared_tick = 1'b0;
    if (main_clk_tick) begin
      if (s_q.gear_cnt >= gear_last(s_q.gear_act)) begin
        s_d.gear_cnt = '0;
        geared_tick  = 1'b1;
        s_d.gear_act = s_q.gear_reg;
      end else begin
        s_d.gear_cnt = s_q.gear_cnt + 1'b1;
      end
    end

    // Sub-clock only counts in dual-clock operation
    sub_ok = sub_tick & s_q.suben_reg;

    // System clock from the active source; switch only on that source's own edge
    // Raw sub edge used so clearing the enable cannot strand the source on sub
    src_tick = (s_q.src_act == SRC_SUB) ? sub_tick : geared_tick;
    // First edge of a new source is swallowed so no half period is cut short
    sys_tick = src_tick & ~s_q.sw_skip;
    next_src = (s_q.src_reg && s_q.suben_reg) ? SRC_SUB : SRC_GEARED;
    if (src_tick && s_q.sw_skip) begin
      s_d.sw_skip = 1'b0;
    end
    if (sys_tick) begin
      s_d.src_act = next_src;
      s_d.sw_skip = (next_src != s_q.src_act);
      s_d.sys_clk = ~s_q.sys_clk;
    end
    s_d.sys_en     = sys_tick;
    s_d.cpu_en     = sys_tick & ~s_q.sleep_reg & ~s_q.in_reset;
    s_d.periph_en  = sys_tick & ~s_q.sleep_reg;
    s_d.sub_en_out = sub_ok;

    // Reset accepted only after twelve system clocks of low input
    if (s_q.rst_sync) begin
      s_d.low_cnt  = '0;
      s_d.in_reset = 1'b0;
    end else if (sys_tick && s_q.low_cnt != `CRG_RESET_LOW_TICKS) begin
      s_d.low_cnt = s_q.low_cnt + 1'b1;
    end
    if (!s_q.rst_sync && s_q.low_cnt == `CRG_RESET_LOW_TICKS) begin
      s_d.in_reset = 1'b1;
    end

    s_d.core_rst_n   = ~s_q.in_reset;
    s_d.cp0_init     = s_q.in_reset;
    s_d.periph_rst_n = ~s_q.in_reset;
    s_d.port_default = s_q.in_reset;

    // APB slave: one wait state, answer from registers
    bus_access = psel & penable & ~s_q.pready;
    // Write lands on the edge at which the master sees pready
    bus_write  = psel & penable & s_q.pready & pwrite;
    unmapped   = paddr != `CRG_CTRL_OFS && paddr != `CRG_STATUS_OFS && paddr != `CRG_VECTOR_OFS;
    rd_word    = '0;
    case (paddr)
      `CRG_CTRL_OFS: begin
        rd_word[`CRG_GEAR_MSB:`CRG_GEAR_LSB] = s_q.gear_reg;
        rd_word[`CRG_SRC_BIT]                = s_q.src_reg;
        rd_word[`CRG_DIVSEL_BIT]             = s_q.divsel_reg;
        rd_word[`CRG_SUBEN_BIT]              = s_q.suben_reg;
        rd_word[`CRG_SLEEP_BIT]              = s_q.sleep_reg;
      end
      `CRG_STATUS_OFS: begin
        rd_word[`CRG_ST_PLL_BIT]                    = s_q.pll_on;
        rd_word[`CRG_ST_GEAR_MSB:`CRG_ST_GEAR_LSB]  = s_q.gear_act;
        rd_word[`CRG_ST_SRC_BIT]                    = s_q.src_act;
        rd_word[`CRG_ST_RST_BIT]                    = s_q.in_reset;
        rd_word[`CRG_ST_PER_MSB:`CRG_ST_PER_LSB]    = 16'(s_q.period);
      end
      `CRG_VECTOR_OFS: begin
        rd_word = `CRG_RESET_VECTOR;
      end
      default: begin
        rd_word = '0;
      end
    endcase
    s_d.pready  = bus_access;
    s_d.pslverr = bus_access & unmapped;
    if (bus_access && !pwrite) begin
      s_d.prdata = rd_word;
    end

    // Gear code 0 is not a ratio; a write of it leaves the gear unchanged
    if (bus_write && paddr == `CRG_CTRL_OFS) begin
      if (pwdata[`CRG_GEAR_MSB:`CRG_GEAR_LSB] != 2'h0) begin
        s_d.gear_reg = pwdata[`CRG_GEAR_MSB:`CRG_GEAR_LSB];
      end
      s_d.src_reg    = pwdata[`CRG_SRC_BIT];
      s_d.divsel_reg = pwdata[`CRG_DIVSEL_BIT];
      s_d.suben_reg  = pwdata[`CRG_SUBEN_BIT];
      s_d.sleep_reg  = pwdata[`CRG_SLEEP_BIT];
    end

    // Qualified reset wins over a bus write in the same cycle
    if (s_q.in_reset) begin
      s_d.gear_reg   = `CRG_GEAR_DIV8;
      s_d.src_reg    = 1'b0;
      s_d.divsel_reg = 1'b0;
      s_d.suben_reg  = 1'b0;
      s_d.sleep_reg  = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q              <= '0;
      s_q.rst_meta     <= 1'b1;
      s_q.rst_sync     <= 1'b1;
      s_q.gear_act     <= `CRG_GEAR_DIV8;
      s_q.gear_reg     <= `CRG_GEAR_DIV8;
      s_q.src_act      <= SRC_GEARED;
      s_q.core_rst_n   <= 1'b0;
      s_q.cp0_init     <= 1'b1;
      s_q.periph_rst_n <= 1'b0;
      s_q.port_default <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Vector is a fixed constant held in a register
  logic [31:0] vector_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_q <= `CRG_RESET_VECTOR;
    end else begin
      vector_q <= `CRG_RESET_VECTOR;
    end
  end

  assign pready           = s_q.pready;
  assign prdata           = s_q.prdata;
  assign pslverr          = s_q.pslverr;
  assign sys_clk          = s_q.sys_clk;
  assign sys_clk_en       = s_q.sys_en;
  assign cpu_clk_en       = s_q.cpu_en;
  assign periph_clk_en    = s_q.periph_en;
  assign rtc_clk_en       = s_q.sub_en_out;
  assign pulse_cnt_clk_en = s_q.sub_en_out;
  assign pullup_clk_en    = s_q.sub_en_out;
  assign core_rst_n       = s_q.core_rst_n;
  assign cp0_init         = s_q.cp0_init;
  assign reset_vector     = vector_q;
  assign periph_rst_n     = s_q.periph_rst_n;
  assign port_default     = s_q.port_default;

endmodule

`default_nettype wire

// ==== sim/osc_src.sv ====
// Oscillator and external reset source facing the clock block
`timescale 1ns/10ps
`default_nettype none

module osc_src #(
  parameter int MH = 8,
  parameter int SH = 20
) (
  // Pin levels
  output logic main_osc_pins,
  output logic sub_osc_pins,
  output logic ext_reset_n
);
  // Odd start offsets keep pin edges clear of pclk edges
  initial begin
    main_osc_pins = 1'b0;
    #7;
    forever #(MH * 40) main_osc_pins = ~main_osc_pins;
  end
  // Sub clock scaled down so runs stay short
  initial begin
    sub_osc_pins = 1'b0;
    #13;
    forever #(SH * 40) sub_osc_pins = ~sub_osc_pins;
  end
  initial ext_reset_n = 1'b1;
  // Pull-up pin: released level is high
  task automatic hold(input int n);
    #5;
    ext_reset_n = 1'b0;
    #(n * 40);
    ext_reset_n = 1'b1;
  endtask
endmodule

`default_nettype wire

// ==== sim/crg_checker.sv ====
// Port assertions for the clock and reset block
`timescale 1ns/10ps
`default_nettype none

module crg_checker (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  // Enables
  input wire logic        sys_clk,
  input wire logic        sys_clk_en,
  input wire logic        cpu_clk_en,
  input wire logic        periph_clk_en,
  input wire logic        rtc_clk_en,
  input wire logic        pulse_cnt_clk_en,
  input wire logic        pullup_clk_en,
  // Reset effects
  input wire logic        core_rst_n,
  input wire logic        cp0_init,
  input wire logic [31:0] reset_vector,
  input wire logic        periph_rst_n,
  input wire logic        port_default
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_vec; reset_vector == 32'hBFC0_0000; endproperty
  a_vec: assert property (p_vec) else $error("reset vector wrong");
  property p_cp0; cp0_init == !core_rst_n; endproperty
  a_cp0: assert property (p_cp0) else $error("cp0 init not tied to core reset");
  property p_per; periph_rst_n == core_rst_n; endproperty
  a_per: assert property (p_per) else $error("peripheral reset mismatch");
  property p_port; port_default == !periph_rst_n; endproperty
  a_port: assert property (p_port) else $error("port default mismatch");
  property p_cpu; cpu_clk_en |-> sys_clk_en && periph_clk_en; endproperty
  a_cpu: assert property (p_cpu) else $error("cpu enable without system tick");
  property p_sub; rtc_clk_en == pulse_cnt_clk_en && pullup_clk_en == rtc_clk_en; endproperty
  a_sub: assert property (p_sub) else $error("sleep domain enables differ");
  property p_gap; sys_clk_en |=> !sys_clk_en; endproperty
  a_gap: assert property (p_gap) else $error("shortened system clock pulse");
  property p_tgl; $changed(sys_clk) == sys_clk_en; endproperty
  a_tgl: assert property (p_tgl) else $error("system clock level not following its tick");
  property p_rdy; psel && penable && !pready |=> pready ##1 !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("bus answer timing wrong");
  property p_slv; pslverr |-> pready; endproperty
  a_slv: assert property (p_slv) else $error("error without ready");

  c_sleep: cover property (rtc_clk_en && !periph_clk_en);
  c_rst: cover property ($fell(core_rst_n));
  c_err: cover property (pready && pslverr);
endmodule

`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the clock and reset block
`include "clock_reset_gear_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module testbench;
  localparam int MH = 8;
  localparam int SH = 20;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        pll_bypass_strap = 1'b1;
  logic [31:0] prdata, reset_vector;
  logic [31:0] rng = 32'hD360_8CF2;
  logic        pready, pslverr, main_osc_pins, sub_osc_pins, ext_reset_n, sys_clk, sys_clk_en;
  logic        cpu_clk_en, periph_clk_en, rtc_clk_en, pulse_cnt_clk_en, pullup_clk_en;
  logic        core_rst_n, cp0_init, periph_rst_n, port_default;
  int          err_count = 0;
  int          cmp_count = 0;

  always #20 pclk = ~pclk;

  osc_src #(.MH(MH), .SH(SH)) i_osc (.main_osc_pins, .sub_osc_pins, .ext_reset_n);
  clock_reset_gear_control i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .main_osc_pins, .sub_osc_pins, .pll_bypass_strap, .ext_reset_n, .sys_clk,
    .sys_clk_en, .cpu_clk_en, .periph_clk_en, .rtc_clk_en, .pulse_cnt_clk_en, .pullup_clk_en,
    .core_rst_n, .cp0_init, .reset_vector, .periph_rst_n, .port_default);

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Expected system tick spacing in pclk cycles
  function automatic int per(input int pll, input int g);
    return (2 * MH << g) / (pll ? 4 : 1);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // First intervals may straddle a gear change, so the last one counts
  task automatic gap(input bit sub, output int p);
    for (int k = 0; k < 4; k++) begin
      p = 0;
      do begin
        @(posedge pclk);
        p++;
      end while ((sub ? pullup_clk_en : sys_clk_en) !== 1'b1 && p < 2000);
    end
  endtask

  task automatic test_done();
    $display("errors=%0d compares=%0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    logic [31:0] r;
    logic        e;
    logic        lo;
    int          p, g;
    integer      nc, nr;
    repeat (16) @(posedge pclk);
    chk(cp0_init & ~core_rst_n & ~periph_rst_n & port_default, 1);
    presetn <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      repeat (60) @(posedge pclk);
      apb(0, `CRG_STATUS_OFS, 0, r, e);
      chk(r[2:0], {2'h3, s[0]});
      gap(0, p);
      chk(p, per(s, 3));
      rng = xs(rng);
      for (int k = 0; k < 3; k++) begin
        g = 1 + (k + rng[7:0]) % 3;
        apb(1, `CRG_CTRL_OFS, g, r, e);
        gap(0, p);
        chk(p, per(s, g));
      end
      apb(1, `CRG_CTRL_OFS, 0, r, e);
      apb(0, `CRG_STATUS_OFS, 0, r, e);
      chk(r[2:1], g);
      if (s == 1) begin
        apb(1, `CRG_CTRL_OFS, 32'h0B, r, e);
        gap(0, p);
        chk(p, 2 * per(s, 3));
      end
      presetn <= 1'b0;
      pll_bypass_strap <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
    end
    repeat (60) @(posedge pclk);
    apb(1, `CRG_CTRL_OFS, 32'h07, r, e);
    repeat (100) @(posedge pclk);
    apb(0, `CRG_STATUS_OFS, 0, r, e);
    chk(r[3], 0);
    apb(1, `CRG_CTRL_OFS, 32'h17, r, e);
    gap(1, p);
    chk(p, 2 * SH);
    apb(0, `CRG_STATUS_OFS, 0, r, e);
    chk(r[3], 1);
    apb(1, `CRG_CTRL_OFS, 32'h33, r, e);
    repeat (4) @(posedge pclk);
    nc = 0;
    nr = 0;
    repeat (400) begin
      @(posedge pclk);
      nc += cpu_clk_en | periph_clk_en;
      nr += pullup_clk_en;
    end
    chk(nc, 0);
    chk(nr, 10);
    apb(1, `CRG_CTRL_OFS, 32'h01, r, e);
    lo = 1'b0;
    fork
      i_osc.hold(40);
      repeat (80) begin
        @(posedge pclk);
        lo |= ~core_rst_n;
      end
    join
    chk(lo, 0);
    fork
      i_osc.hold(300);
      begin
        repeat (290) @(posedge pclk);
        chk({core_rst_n, port_default}, 2'b01);
      end
    join
    repeat (10) @(posedge pclk);
    apb(0, `CRG_CTRL_OFS, 0, r, e);
    chk(r, 32'h03);
    apb(0, `CRG_VECTOR_OFS, 0, r, e);
    chk(r, 32'hBFC0_0000);
    rng = xs(rng);
    apb(1, 12'h00C, rng, r, e);
    chk(e, 1);
    apb(0, `CRG_CTRL_OFS, 0, r, e);
    chk(r, 32'h03);
    test_done();
  end

  initial begin
    #(40 * 40000);
    err_count++;
    test_done();
  end
endmodule

bind clock_reset_gear_control crg_checker i_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .sys_clk, .sys_clk_en, .cpu_clk_en, .periph_clk_en, .rtc_clk_en, .pulse_cnt_clk_en, .pullup_clk_en,
  .core_rst_n, .cp0_init, .reset_vector, .periph_rst_n, .port_default);

`default_nettype wire
